// File: src/hsb_params.svh
// Timing and framing constants of the host serial and boot port
`ifndef HSB_PARAMS_SVH
`define HSB_PARAMS_SVH
`define HSB_CLK_NS 50
`define HSB_ADDR_BITS 7
`define HSB_FRAME_BITS 16
`define HSB_SYNC_LAT 3
`define HSB_SYNC_INIT 12'h006
`define HSB_ACC_NS 920
`define HSB_ACC_CYC ((`HSB_ACC_NS + `HSB_CLK_NS - 1) / `HSB_CLK_NS)
`define HSB_GRADE_NS 250
`define HSB_GRADE_CYC ((`HSB_GRADE_NS + `HSB_CLK_NS - 1) / `HSB_CLK_NS)
`define HSB_RDY_LOW_NS 173
`define HSB_RDY_LOW_CYC (`HSB_RDY_LOW_NS / `HSB_CLK_NS)
`define HSB_GAP_NS 1600
`define HSB_GAP_CYC ((`HSB_GAP_NS + `HSB_CLK_NS - 1) / `HSB_CLK_NS)
`define HSB_HOLD_MS 250
`define HSB_HOLD_CYC (`HSB_HOLD_MS * 1000000 / `HSB_CLK_NS)
`define HSB_REG_DEFAULT 8'h00
`endif

// File: src/hsb_pkg.sv
// Types shared by both ends of the host serial and boot port
package hsb_pkg;
    typedef enum logic [1:0] {MODE_SERIAL, MODE_MUX, MODE_BOOT} hsb_mode_t;
    typedef enum logic [1:0] {OP_SER_WR, OP_SER_RD, OP_MUX_WR} hsb_op_t;
endpackage

// File: src/hsb_link.sv
// Link between the host and the device: serial, multiplexed and boot pins
`timescale 1ns/1ps
interface hsb_link;
    logic sclk;
    logic chip_select_n;
    logic serial_data_in;
    logic serial_data_out;
    logic sdo_oe;
    logic sdo_line;
    logic ale;
    logic write_strobe_n;
    logic [7:0] ad_host;
    logic ad_host_oe;
    logic [7:0] eprom_data;
    logic [7:0] ad_bus;
    logic ready_out;
    logic ready_oe;
    logic ready_line;
    logic [6:0] eprom_addr;
    logic eprom_cs_n;
    // Released sdo and ready lines read high, as with a pull-up; the released bus shows the EPROM data
    assign sdo_line = sdo_oe ? serial_data_out : 1'b1;
    assign ready_line = ready_oe ? ready_out : 1'b1;
    assign ad_bus = ad_host_oe ? ad_host : eprom_data;
    modport dev (
        input sclk, chip_select_n, serial_data_in, ale, write_strobe_n,
        input ad_bus,
        output serial_data_out, sdo_oe, ready_out, ready_oe,
        output eprom_addr, eprom_cs_n
    );
    modport host (
        output sclk, chip_select_n, serial_data_in, ale, write_strobe_n,
        output ad_host, ad_host_oe,
        input sdo_line, ready_line
    );
endinterface

// File: src/hsb_host.sv
// Host end: serial master with its own clock divider and multiplexed writer
`timescale 1ns/1ps
`include "hsb_params.svh"
module hsb_host import hsb_pkg::*; #(
    parameter int DIV = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire hsb_op_t op,
    input wire logic [`HSB_ADDR_BITS-1:0] addr,
    input wire logic [7:0] wdata,
    output logic busy,
    output logic done,
    output logic [7:0] rdata,
    hsb_link.host link
);
    localparam int GAP_CYC = `HSB_GAP_CYC;
    typedef enum logic [2:0] {
        H_IDLE, H_SER, H_ALE, H_ADR, H_WRL, H_WRH, H_HOLD, H_GAP
    } hsb_hstate_t;

    // ======================================================
    // Ready synchroniser
    logic r1_reg, r2_reg, r3_reg, rf_reg, rf_next;
    always_comb begin
        rf_next = (r2_reg == r3_reg) ? r3_reg : rf_reg;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r1_reg <= 1'b1;
            r2_reg <= 1'b1;
            r3_reg <= 1'b1;
            rf_reg <= 1'b1;
        end else begin
            r1_reg <= link.ready_line;
            r2_reg <= r1_reg;
            r3_reg <= r2_reg;
            rf_reg <= rf_next;
        end
    end

    // ======================================================
    // Access sequencer
    hsb_hstate_t st_reg, st_next;
    logic [7:0] div_reg, div_next, gap_reg, gap_next;
    logic [4:0] edge_reg, edge_next;
    logic [15:0] word_reg, word_next;
    logic [7:0] rx_reg, rx_next, ad_reg, ad_next, rdata_reg, rdata_next;
    logic sclk_reg, sclk_next, cs_reg, cs_next, sdi_reg, sdi_next;
    logic rd_reg, rd_next, ale_reg, ale_next, wr_reg, wr_next;
    logic adoe_reg, adoe_next, busy_reg, busy_next, done_reg, done_next;

    always_comb begin
        st_next = st_reg;
        div_next = div_reg;
        gap_next = gap_reg;
        edge_next = edge_reg;
        word_next = word_reg;
        rx_next = rx_reg;
        ad_next = ad_reg;
        rdata_next = rdata_reg;
        sclk_next = sclk_reg;
        cs_next = cs_reg;
        sdi_next = sdi_reg;
        rd_next = rd_reg;
        ale_next = ale_reg;
        wr_next = wr_reg;
        adoe_next = adoe_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        unique case (st_reg)
            H_IDLE: begin
                if (req) begin
                    busy_next = 1'b1;
                    cs_next = 1'b0;
                    if (op == OP_MUX_WR) begin
                        ale_next = 1'b1;
                        ad_next = {1'b0, addr};
                        adoe_next = 1'b1;
                        st_next = H_ALE;
                    end else begin
                        rd_next = (op == OP_SER_RD);
                        word_next = {wdata, op == OP_SER_RD, addr};
                        sdi_next = addr[0];
                        edge_next = 5'd0;
                        div_next = 8'(DIV - 1);
                        st_next = H_SER;
                    end
                end
            end
            H_SER: begin
                if (div_reg != 8'h00) begin
                    div_next = div_reg - 8'h01;
                end else begin
                    div_next = 8'(DIV - 1);
                    if (!sclk_reg) begin
                        sclk_next = 1'b1;
                        if (rd_reg && word_reg[1] && edge_reg[3]) begin
                            rx_next[edge_reg[2:0]] = link.sdo_line;
                        end
                        edge_next = edge_reg + 5'd1;
                    end else begin
                        sclk_next = 1'b0;
                        if (rd_reg && !word_reg[1] && edge_reg[3]
                            && !edge_reg[4]) begin
                            rx_next[edge_reg[2:0]] = link.sdo_line;
                        end
                        if (edge_reg == 5'd16) begin
                            cs_next = 1'b1;
                            rdata_next = rx_reg;
                            done_next = 1'b1;
                            busy_next = 1'b0;
                            st_next = H_IDLE;
                        end else begin
                            sdi_next = word_reg[edge_reg[3:0]];
                        end
                    end
                end
            end
            H_ALE: begin
                ale_next = 1'b0;
                st_next = H_ADR;
            end
            H_ADR: begin
                ad_next = wdata;
                wr_next = 1'b0;
                st_next = H_WRL;
            end
            H_WRL: begin
                if (!rf_reg) begin
                    st_next = H_WRH;
                end
            end
            H_WRH: begin
                if (rf_reg) begin
                    wr_next = 1'b1;
                    st_next = H_HOLD;
                end
            end
            H_HOLD: begin
                adoe_next = 1'b0;
                cs_next = 1'b1;
                gap_next = 8'(GAP_CYC - 2);
                st_next = H_GAP;
            end
            H_GAP: begin
                if (gap_reg == 8'h00) begin
                    done_next = 1'b1;
                    busy_next = 1'b0;
                    st_next = H_IDLE;
                end else begin
                    gap_next = gap_reg - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= H_IDLE;
            div_reg <= 8'h00;
            gap_reg <= 8'h00;
            edge_reg <= 5'h00;
            word_reg <= 16'h0000;
            rx_reg <= 8'h00;
            ad_reg <= 8'h00;
            rdata_reg <= 8'h00;
            sclk_reg <= 1'b0;
            cs_reg <= 1'b1;
            sdi_reg <= 1'b0;
            rd_reg <= 1'b0;
            ale_reg <= 1'b0;
            wr_reg <= 1'b1;
            adoe_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            div_reg <= div_next;
            gap_reg <= gap_next;
            edge_reg <= edge_next;
            word_reg <= word_next;
            rx_reg <= rx_next;
            ad_reg <= ad_next;
            rdata_reg <= rdata_next;
            sclk_reg <= sclk_next;
            cs_reg <= cs_next;
            sdi_reg <= sdi_next;
            rd_reg <= rd_next;
            ale_reg <= ale_next;
            wr_reg <= wr_next;
            adoe_reg <= adoe_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign link.sclk = sclk_reg;
    assign link.chip_select_n = cs_reg;
    assign link.serial_data_in = sdi_reg;
    assign link.ale = ale_reg;
    assign link.write_strobe_n = wr_reg;
    assign link.ad_host = ad_reg;
    assign link.ad_host_oe = adoe_reg;
    assign busy = busy_reg;
    assign done = done_reg;
    assign rdata = rdata_reg;
endmodule

// File: src/hsb_device.sv
// Device end: serial slave, multiplexed write, boot loader, power-on reset
`timescale 1ns/1ps
`include "hsb_params.svh"
module hsb_device import hsb_pkg::*; #(
    parameter int NREG = 128,
    parameter int HOLD_CYC = `HSB_HOLD_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic power_on_reset_n,
    input wire logic [1:0] mode_strap,
    input wire logic [`HSB_ADDR_BITS-1:0] user_addr,
    output logic [7:0] user_data,
    output logic running,
    output logic boot_done,
    hsb_link.dev link
);
    localparam int AW = `HSB_ADDR_BITS;
    localparam int NS = 12;
    localparam int ACC = `HSB_ACC_CYC;
    localparam int GRADE = `HSB_GRADE_CYC;
    // The pin is sampled four edges before the write, at the first edge past the access time
    localparam int BOOT_WAIT = (ACC > GRADE ? ACC : GRADE) + `HSB_SYNC_LAT + 1;
    localparam int RDY_CYC = `HSB_RDY_LOW_CYC;
    localparam logic [NS-1:0] SYNC_INIT = `HSB_SYNC_INIT;
    typedef enum logic [1:0] {B_IDLE, B_LOAD, B_DONE} hsb_bstate_t;

    // ======================================================
    // Power-on reset and hold
    logic por_rst;
    // short low pulse resets at once
    assign por_rst = rst | ~power_on_reset_n;

    logic [31:0] hold_reg, hold_next;
    logic run_reg, run_next;
    hsb_mode_t mode_reg, mode_next;
    always_comb begin
        hold_next = hold_reg;
        run_next = run_reg;
        mode_next = mode_reg;
        if (!run_reg) begin
            if (hold_reg == 32'(HOLD_CYC - 1)) begin
                run_next = 1'b1;
                mode_next = hsb_mode_t'(mode_strap);
            end else begin
                hold_next = hold_reg + 32'd1;
            end
        end
    end
    always_ff @(posedge clk or posedge por_rst) begin
        if (por_rst) begin
            hold_reg <= 32'h00000000;
            run_reg <= 1'b0;
            mode_reg <= MODE_SERIAL;
        end else begin
            hold_reg <= hold_next;
            run_reg <= run_next;
            mode_reg <= mode_next;
        end
    end

    // ======================================================
    // Input synchronisers
    logic tgl_reg;
    logic [NS-1:0] sin;
    logic [NS-1:0] s1_reg, s2_reg, s3_reg, f_reg, f_next;
    logic [2:0] fp_reg;
    assign sin = {link.ad_bus, link.ale, link.write_strobe_n,
                  link.chip_select_n, tgl_reg};
    // Change counts once the second and third stages agree
    for (genvar i = 0; i < NS; i++) begin : g_sync
        always_comb begin
            f_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : f_reg[i];
        end
        always_ff @(posedge clk or posedge por_rst) begin
            if (por_rst) begin
                s1_reg[i] <= SYNC_INIT[i];
                s2_reg[i] <= SYNC_INIT[i];
                s3_reg[i] <= SYNC_INIT[i];
                f_reg[i] <= SYNC_INIT[i];
            end else begin
                s1_reg[i] <= sin[i];
                s2_reg[i] <= s1_reg[i];
                s3_reg[i] <= s2_reg[i];
                f_reg[i] <= f_next[i];
            end
        end
    end
    always_ff @(posedge clk or posedge por_rst) begin
        if (por_rst) begin
            fp_reg <= 3'h6;
        end else begin
            fp_reg <= f_reg[2:0];
        end
    end

    logic ser_ev, mux_ev, wr_fall;
    assign ser_ev = run_reg && mode_reg == MODE_SERIAL
                    && (f_reg[0] != fp_reg[0]);
    assign mux_ev = run_reg && mode_reg == MODE_MUX && f_reg[2] && !fp_reg[2];
    assign wr_fall = run_reg && mode_reg == MODE_MUX && !f_reg[2] && fp_reg[2];

    // ======================================================
    // Multiplexed write port
    logic [AW-1:0] mux_addr_reg;
    logic [7:0] mux_data_reg;
    always_ff @(negedge link.ale or posedge por_rst) begin
        if (por_rst) begin
            mux_addr_reg <= '0;
        end else begin
            mux_addr_reg <= link.ad_bus[AW-1:0];
        end
    end
    always_ff @(posedge link.write_strobe_n or posedge por_rst) begin
        if (por_rst) begin
            mux_data_reg <= 8'h00;
        end else begin
            mux_data_reg <= link.ad_bus;
        end
    end

    logic rdy_low_reg, rdy_low_next, rdy_oe_reg, rdy_oe_next;
    logic rdy_out_reg, rdy_out_next;
    logic [3:0] rdy_cnt_reg, rdy_cnt_next;
    always_comb begin
        rdy_low_next = rdy_low_reg;
        rdy_cnt_next = rdy_cnt_reg;
        // drive while selected, low after strobe
        rdy_oe_next = run_reg && mode_reg == MODE_MUX && !f_reg[1];
        if (wr_fall) begin
            rdy_low_next = 1'b1;
            rdy_cnt_next = 4'(RDY_CYC - 1);
        end else if (rdy_low_reg) begin
            if (rdy_cnt_reg == 4'h0) begin
                rdy_low_next = 1'b0;
            end else begin
                rdy_cnt_next = rdy_cnt_reg - 4'h1;
            end
        end
        // Ready leaves straight from a flop
        rdy_out_next = ~rdy_low_next;
    end
    always_ff @(posedge clk or posedge por_rst) begin
        if (por_rst) begin
            rdy_low_reg <= 1'b0;
            rdy_cnt_reg <= 4'h0;
            rdy_oe_reg <= 1'b0;
            rdy_out_reg <= 1'b1;
        end else begin
            rdy_low_reg <= rdy_low_next;
            rdy_cnt_reg <= rdy_cnt_next;
            rdy_oe_reg <= rdy_oe_next;
            rdy_out_reg <= rdy_out_next;
        end
    end

    // ======================================================
    // Boot loader
    hsb_bstate_t bst_reg, bst_next;
    logic [AW-1:0] baddr_reg, baddr_next;
    logic [7:0] bcnt_reg, bcnt_next;
    logic bcs_reg, bcs_next;
    logic bdone_reg, bdone_next;
    logic bwe;
    always_comb begin
        bst_next = bst_reg;
        baddr_next = baddr_reg;
        bcnt_next = bcnt_reg;
        bcs_next = bcs_reg;
        bwe = 1'b0;
        unique case (bst_reg)
            B_IDLE: begin
                if (run_reg && mode_reg == MODE_BOOT) begin
                    bcs_next = 1'b0;
                    bcnt_next = 8'(BOOT_WAIT - 1);
                    bst_next = B_LOAD;
                end
            end
            B_LOAD: begin
                if (bcnt_reg != 8'h00) begin
                    bcnt_next = bcnt_reg - 8'h01;
                end else begin
                    bwe = 1'b1;
                    bcnt_next = 8'(BOOT_WAIT - 1);
                    if (baddr_reg == AW'(NREG - 1)) begin
                        bcs_next = 1'b1;
                        bst_next = B_DONE;
                    end else begin
                        baddr_next = baddr_reg + AW'(1);
                    end
                end
            end
            B_DONE: begin
                bst_next = B_DONE;
            end
            default: begin
                bst_next = B_IDLE;
            end
        endcase
        bdone_next = (bst_next == B_DONE);
    end
    always_ff @(posedge clk or posedge por_rst) begin
        if (por_rst) begin
            bst_reg <= B_IDLE;
            baddr_reg <= '0;
            bcnt_reg <= 8'h00;
            bcs_reg <= 1'b1;
            bdone_reg <= 1'b0;
        end else begin
            bst_reg <= bst_next;
            baddr_reg <= baddr_next;
            bcnt_reg <= bcnt_next;
            bcs_reg <= bcs_next;
            bdone_reg <= bdone_next;
        end
    end

    // ======================================================
    // Register file
    logic [7:0] regs [NREG];
    logic [7:0] user_reg;
    logic [AW-1:0] hold_addr_reg;
    logic [7:0] hold_data_reg;
    logic we;
    logic [AW-1:0] wa;
    logic [7:0] wd;
    always_comb begin
        we = bwe | ser_ev | mux_ev;
        wa = mux_addr_reg;
        wd = mux_data_reg;
        if (bwe) begin
            wa = baddr_reg;
            wd = f_reg[11:4];
        end else if (ser_ev) begin
            wa = hold_addr_reg;
            wd = hold_data_reg;
        end
    end
    always_ff @(posedge clk or posedge por_rst) begin
        if (por_rst) begin
            for (int i = 0; i < NREG; i++) begin
                regs[i] <= `HSB_REG_DEFAULT;
            end
        end else if (we) begin
            regs[wa] <= wd;
        end
    end
    always_ff @(posedge clk or posedge por_rst) begin
        if (por_rst) begin
            user_reg <= 8'h00;
        end else begin
            user_reg <= regs[user_addr];
        end
    end

    // ======================================================
    // Serial slave, on the link clock
    // Select high clears it, so idle clock edges never matter
    logic [15:0] rx_reg, rx_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [7:0] tx_reg, tx_next;
    logic rd_reg, rd_next, fall_reg;
    always_comb begin
        rx_next = rx_reg;
        cnt_next = cnt_reg;
        tx_next = tx_reg;
        rd_next = rd_reg;
        if (cnt_reg != 5'd16) begin
            rx_next[cnt_reg[3:0]] = link.serial_data_in;
            cnt_next = cnt_reg + 5'd1;
        end
        if (cnt_reg == 5'd7) begin
            rd_next = link.serial_data_in;
            tx_next = regs[rx_reg[AW-1:0]];
        end else if (rd_reg) begin
            tx_next = {1'b0, tx_reg[7:1]};
        end
    end
    always_ff @(posedge link.sclk or posedge link.chip_select_n) begin
        if (link.chip_select_n) begin
            rx_reg <= 16'h0000;
            cnt_reg <= 5'd0;
            tx_reg <= 8'h00;
            rd_reg <= 1'b0;
        end else begin
            rx_reg <= rx_next;
            cnt_reg <= cnt_next;
            tx_reg <= tx_next;
            rd_reg <= rd_next;
        end
    end
    always_ff @(negedge link.sclk or posedge link.chip_select_n) begin
        if (link.chip_select_n) begin
            fall_reg <= 1'b0;
        end else begin
            fall_reg <= tx_reg[0];
        end
    end
    // Held words stay put for a whole frame, long enough to cross
    always_ff @(posedge link.sclk or posedge por_rst) begin
        if (por_rst) begin
            hold_addr_reg <= '0;
            hold_data_reg <= 8'h00;
            tgl_reg <= 1'b0;
        end else if (!link.chip_select_n && cnt_reg == 5'd15 && !rd_reg) begin
            hold_addr_reg <= rx_reg[AW-1:0];
            hold_data_reg <= {link.serial_data_in, rx_reg[14:8]};
            tgl_reg <= ~tgl_reg;
        end
    end

    // edge select is address bit one
    assign link.serial_data_out = rx_reg[1] ? fall_reg : tx_reg[0];
    assign link.sdo_oe = rd_reg;
    assign link.ready_out = rdy_out_reg;
    assign link.ready_oe = rdy_oe_reg;
    assign link.eprom_addr = baddr_reg;
    assign link.eprom_cs_n = bcs_reg;
    assign user_data = user_reg;
    assign running = run_reg;
    assign boot_done = bdone_reg;
endmodule

// File: dv/hsb_link_sva.sv
// Checker of the signals on the host serial and boot link
`timescale 1ns/1ps
module hsb_link_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic power_on_reset_n,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic sdo_oe,
    input wire logic ale,
    input wire logic write_strobe_n,
    input wire logic ready_out,
    input wire logic ready_oe,
    input wire logic [6:0] eprom_addr,
    input wire logic eprom_cs_n
);
    // ==========================================
    // Helper counters
    logic wr_q_reg;
    logic [6:0] addr_q_reg;
    logic [5:0] gap_reg, gap_next, held_reg, held_next;
    always_comb begin
        gap_next = (gap_reg == 6'h3f) ? gap_reg : gap_reg + 6'h01;
        if (write_strobe_n && !wr_q_reg) gap_next = 6'h00;
        held_next = (held_reg == 6'h3f) ? held_reg : held_reg + 6'h01;
        if (eprom_cs_n || eprom_addr != addr_q_reg) held_next = 6'h00;
    end
    // Gap starts saturated so the first access is never flagged
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q_reg <= 1'b1;
            addr_q_reg <= 7'h00;
            gap_reg <= 6'h3f;
            held_reg <= 6'h00;
        end else begin
            wr_q_reg <= write_strobe_n;
            addr_q_reg <= eprom_addr;
            gap_reg <= gap_next;
            held_reg <= held_next;
        end
    end
    // ==========================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !power_on_reset_n);
    a_sclk_idle_low: assert property (
        chip_select_n |-> !sclk) else $error("sclk moved outside frame");
    a_sdo_idle_off: assert property (
        (chip_select_n && $past(chip_select_n, 6)) |-> !sdo_oe)
        else $error("sdo driven outside frame");
    a_rdy_on_strobe: assert property (
        $fell(write_strobe_n) |-> ##[1:8] (ready_oe && !ready_out))
        else $error("ready not pulled low");
    a_strobe_held_low: assert property (
        (!write_strobe_n && ready_oe && !ready_out) |=> !write_strobe_n)
        else $error("strobe released while ready low");
    a_rdy_released: assert property (
        $rose(chip_select_n) |-> ##[1:6] !ready_oe)
        else $error("ready not released");
    a_mux_access_gap: assert property (
        $rose(ale) |-> gap_reg >= 6'h1f) else $error("access gap short");
    // Access time plus the four synchroniser edges before the write
    a_boot_addr_hold: assert property (
        (!eprom_cs_n && !$past(eprom_cs_n) && eprom_addr != addr_q_reg)
        |-> held_reg >= 6'h16) else $error("boot address held too short");
    a_boot_steps_up: assert property (
        (!eprom_cs_n && !$past(eprom_cs_n) && eprom_addr != addr_q_reg)
        |-> eprom_addr == addr_q_reg + 7'h01) else $error("boot skipped");
endmodule

// File: dv/testbench.sv
// Self-checking bench joining the host and device ends
`timescale 1ns/1ps
module testbench import hsb_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic power_on_reset_n = 1'b1;
    logic req = 1'b0;
    hsb_op_t op = OP_SER_WR;
    logic [6:0] addr = 7'h00;
    logic [7:0] wdata = 8'h00;
    logic [1:0] mode_strap = 2'h0;
    logic [6:0] user_addr = 7'h00;
    logic busy, done, running, boot_done;
    logic [7:0] rdata, user_data;
    localparam int HOLD = 8;
    logic [15:0] frm = 16'h0000;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    hsb_link link ();
    // EPROM contents follow a pattern of the address
    assign link.eprom_data = {1'b0, link.eprom_addr} ^ 8'ha5;
    always #25 clk = ~clk;
    hsb_host hsb_host_inst (.clk, .rst, .req, .op, .addr, .wdata, .busy,
        .done, .rdata, .link(link.host));
    hsb_device #(.HOLD_CYC(HOLD)) hsb_device_inst (.clk, .rst,
        .power_on_reset_n, .mode_strap, .user_addr, .user_data, .running,
        .boot_done, .link(link.dev));
    hsb_link_sva hsb_link_sva_inst (.clk, .rst, .power_on_reset_n,
        .sclk(link.sclk), .chip_select_n(link.chip_select_n),
        .sdo_oe(link.sdo_oe), .ale(link.ale),
        .write_strobe_n(link.write_strobe_n), .ready_out(link.ready_out),
        .ready_oe(link.ready_oe), .eprom_addr(link.eprom_addr),
        .eprom_cs_n(link.eprom_cs_n));
    // Wire-side record of the serial frame as shifted
    always @(posedge link.sclk) begin
        if (!link.chip_select_n) frm <= {link.serial_data_in, frm[15:1]};
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic go(input logic [1:0] m);
        mode_strap <= m;
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Hold ends exactly HOLD edges after release
        repeat (HOLD) @(posedge clk);
        cmp(running, 1'b0);
        @(posedge clk);
        cmp(running, 1'b1);
    endtask
    task automatic xfer(input hsb_op_t o, input logic [6:0] a,
        input logic [7:0] d);
        int i;
        req <= 1'b1;
        op <= o;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        cmp(busy, 1'b1);
        for (i = 0; i < 200 && done !== 1'b1; i++) @(posedge clk);
        cmp(done, 1'b1);
        cmp(busy, 1'b0);
    endtask
    task automatic rd_user(input logic [6:0] a, input logic [7:0] e);
        user_addr <= a;
        repeat (3) @(posedge clk);
        cmp(user_data, e);
    endtask
    task automatic t_serial;
        go(2'h0);
        xfer(OP_SER_WR, 7'h05, 8'h3c);
        cmp(frm, {8'h3c, 1'b0, 7'h05});
        xfer(OP_SER_WR, 7'h06, 8'ha5);
        xfer(OP_SER_RD, 7'h05, 8'h00);
        cmp(rdata, 8'h3c);
        xfer(OP_SER_RD, 7'h06, 8'h00);
        cmp(rdata, 8'ha5);
        rd_user(7'h06, 8'ha5);
        $display("serial test ended");
    endtask
    task automatic t_mux;
        go(2'h1);
        rd_user(7'h05, 8'h00);
        xfer(OP_MUX_WR, 7'h09, 8'h5a);
        xfer(OP_MUX_WR, 7'h0a, 8'hc3);
        // Serial writes are ignored outside serial mode
        xfer(OP_SER_WR, 7'h0b, 8'h77);
        rd_user(7'h09, 8'h5a);
        rd_user(7'h0a, 8'hc3);
        rd_user(7'h0b, 8'h00);
        $display("multiplexed test ended");
    endtask
    task automatic t_boot;
        int i;
        go(2'h2);
        for (i = 0; i < 4000 && boot_done !== 1'b1; i++) @(posedge clk);
        cmp(boot_done, 1'b1);
        cmp(link.eprom_cs_n, 1'b1);
        rd_user(7'h00, 8'ha5);
        rd_user(7'h7f, 8'hda);
        // A 10 ns low pulse must be enough to reset
        power_on_reset_n <= 1'b0;
        power_on_reset_n <= #10 1'b1;
        repeat (3) @(posedge clk);
        cmp(running, 1'b0);
        cmp(boot_done, 1'b0);
        $display("boot test ended");
    endtask
    initial begin
        @(posedge clk);
        t_serial();
        t_mux();
        t_boot();
        test_done();
    end
endmodule
